/* File: logic/ccdgr_pkg.sv */
// ccdgr_pkg: offsets, field positions, reset values and timing of the
// readout geometry register bank.
// assumes a 100 MHz clock and the host port's 4-bit byte offsets.
package ccdgr_pkg;

  // --------------------------------------------------------------
  // register offsets on the host port
  // --------------------------------------------------------------
  localparam logic [3:0] OFS_PIXEL_DATA = 4'h0;
  localparam logic [3:0] OFS_MEAS_TEMP = 4'h2;
  localparam logic [3:0] OFS_TRAIL_SKIP = 4'h6;
  localparam logic [3:0] OFS_SETPOINT = 4'h8;
  localparam logic [3:0] OFS_LINE_PIX = 4'hA;
  localparam logic [3:0] OFS_ROW_COUNT = 4'hC;
  localparam logic [3:0] OFS_LEAD_SKIP = 4'hE;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int CNT_MSB = 11;
  localparam int OPT_LSB = 12;
  localparam int OPT_MSB = 15;
  localparam int HBIN_LSB = 12;
  localparam int HBIN_MSB = 14;
  localparam int TEMP_MSB = 7;
  localparam int RELAY_LSB = 8;
  localparam int RELAY_MSB = 15;
  localparam int CNT_W = 13;
  localparam int BIN_W = 4;

  // --------------------------------------------------------------
  // reset and fill values
  // --------------------------------------------------------------
  localparam logic [11:0] RST_COUNT = 12'h000;
  localparam logic [3:0] RST_OPT = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_HBIN = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHIFT_TIME_NS = 100;
  localparam int SHIFT_CYCLES = (SHIFT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------
  // line sequencer states
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_LEAD = 2'b01,
    LS_DIGI = 2'b11,
    LS_TRAIL = 2'b10
  } ccdgr_state_t;

endpackage : ccdgr_pkg

/* File: logic/ccdgr_tick_div.sv */
// ccdgr_tick_div: one-cycle enable every DIV clocks while run is high.
// assumes run stays high for the whole of a line or flush.
module ccdgr_tick_div
#(
  parameter int DIV = 10
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic run,
  output logic tick
);

  localparam logic [7:0] LAST = 8'(DIV - 1);

  logic [7:0] cnt_reg;
  logic tick_reg;

  // restart on each run so the first tick is a full period away
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end
    else if (!run)
    begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end
    else if (cnt_reg == LAST)
    begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;

endmodule : ccdgr_tick_div

/* File: logic/ccdgr_down_cnt.sv */
// ccdgr_down_cnt: loadable down counter flagging its final step.
// assumes load_val is never zero while counting is wanted.
module ccdgr_down_cnt
#(
  parameter int W = 13
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic dec,
  output logic last
);

  logic [W-1:0] cnt_reg;

  // load beats dec so a reload on the final step starts afresh
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= load_val;
    else if (dec && (cnt_reg != '0))
      cnt_reg <= cnt_reg - W'(1);
  end

  assign last = (cnt_reg == W'(1));

endmodule : ccdgr_down_cnt

/* File: logic/ccdgr_regs.sv */
// ccdgr_regs: readout geometry registers with line and flush sequencing.
// assumes host strobes are one cycle wide and synchronous to clk;
// the pixel source holds pixel_data until pixel_pop.
module ccdgr_regs
  import ccdgr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host register port
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  // readout data
  input wire logic [15:0] pixel_data,
  input wire logic [7:0] temp_raw,
  output logic pixel_pop,
  // sequencing
  input wire logic line_start,
  input wire logic flush_start,
  output logic col_shift,
  output logic adc_sample,
  output logic line_done,
  output logic row_shift,
  output logic frame_done,
  // cooler and factory options
  output logic [7:0] temp_setpoint,
  output logic [7:0] relay_ctrl,
  output logic [3:0] factory_options_a,
  output logic [3:0] factory_options_b,
  output logic [3:0] factory_options_c
);

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [11:0] trail_reg, pix_reg, rows_reg, lead_reg;
  logic [3:0] opt_a_reg, opt_b_reg, opt_c_reg;
  logic [7:0] setpoint_reg, relay_reg;
  logic [2:0] hbin_reg;
  logic [3:0] hbin_line_reg;
  logic [15:0] rdata_reg;
  logic pop_reg, col_reg, adc_reg, ldone_reg, rshift_reg;
  logic frame_reg, row_active_reg;
  ccdgr_state_t state_reg, state_next;
  logic tick, lead_last, pix_last, trail_last, row_last, bin_last;
  logic wr_trail, wr_set, wr_pix, wr_rows, wr_lead;
  logic start_line, in_lead, in_digi, in_trail, sample, row_fin;
  logic [3:0] hbin_eff;

  assign wr_trail = bus_wr && (bus_addr == OFS_TRAIL_SKIP);
  assign wr_set = bus_wr && (bus_addr == OFS_SETPOINT);
  assign wr_pix = bus_wr && (bus_addr == OFS_LINE_PIX);
  assign wr_rows = bus_wr && (bus_addr == OFS_ROW_COUNT);
  assign wr_lead = bus_wr && (bus_addr == OFS_LEAD_SKIP);

  // --------------------------------------------------------------
  // write-only registers
  // --------------------------------------------------------------
  // trailing skip capture
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trail_reg <= RST_COUNT;
      opt_b_reg <= RST_OPT;
    end
    else if (wr_trail)
    begin
      trail_reg <= bus_wdata[CNT_MSB:0];
      opt_b_reg <= bus_wdata[OPT_MSB:OPT_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      setpoint_reg <= RST_BYTE;
      relay_reg <= RST_BYTE;
    end
    else if (wr_set)
    begin
      setpoint_reg <= bus_wdata[TEMP_MSB:0];
      relay_reg <= bus_wdata[RELAY_MSB:RELAY_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pix_reg <= RST_COUNT;
      hbin_reg <= RST_HBIN;
    end
    else if (wr_pix)
    begin
      pix_reg <= bus_wdata[CNT_MSB:0];
      hbin_reg <= bus_wdata[HBIN_MSB:HBIN_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rows_reg <= RST_COUNT;
      opt_c_reg <= RST_OPT;
    end
    else if (wr_rows)
    begin
      rows_reg <= bus_wdata[CNT_MSB:0];
      opt_c_reg <= bus_wdata[OPT_MSB:OPT_LSB];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lead_reg <= RST_COUNT;
      opt_a_reg <= RST_OPT;
    end
    else if (wr_lead)
    begin
      lead_reg <= bus_wdata[CNT_MSB:0];
      opt_a_reg <= bus_wdata[OPT_MSB:OPT_LSB];
    end
  end

  // --------------------------------------------------------------
  // read ports
  // --------------------------------------------------------------
  // pixel read pops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= RST_WORD;
      pop_reg <= 1'b0;
    end
    else
    begin
      pop_reg <= bus_rd && (bus_addr == OFS_PIXEL_DATA);
      if (bus_rd)
      begin
        if (bus_addr == OFS_PIXEL_DATA)
          rdata_reg <= pixel_data;
        else if (bus_addr == OFS_MEAS_TEMP)
          rdata_reg <= {RSVD_BYTE, temp_raw};
        else
          rdata_reg <= RST_WORD;
      end
    end
  end

  // --------------------------------------------------------------
  // line sequencer
  // --------------------------------------------------------------
  assign start_line = (state_reg == LS_IDLE) && line_start;
  assign in_lead = (state_reg == LS_LEAD);
  assign in_digi = (state_reg == LS_DIGI);
  assign in_trail = (state_reg == LS_TRAIL);
  assign sample = in_digi && tick && bin_last;
  assign hbin_eff = (hbin_reg == RST_HBIN) ? 4'h1 : {1'b0, hbin_reg};

  ccdgr_tick_div #(.DIV(SHIFT_CYCLES)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .run((state_reg != LS_IDLE) || row_active_reg),
    .tick(tick)
  );

  ccdgr_down_cnt #(.W(CNT_W)) u_lead (
    .clk(clk),
    .arst_n(arst_n),
    .load(start_line),
    .load_val({lead_reg == RST_COUNT, lead_reg}),
    .dec(in_lead && tick),
    .last(lead_last)
  );

  ccdgr_down_cnt #(.W(CNT_W)) u_pix (
    .clk(clk),
    .arst_n(arst_n),
    .load(start_line),
    .load_val({pix_reg == RST_COUNT, pix_reg}),
    .dec(sample),
    .last(pix_last)
  );

  ccdgr_down_cnt #(.W(BIN_W)) u_bin (
    .clk(clk),
    .arst_n(arst_n),
    .load(start_line || sample),
    .load_val(start_line ? hbin_eff : hbin_line_reg),
    .dec(in_digi && tick),
    .last(bin_last)
  );

  ccdgr_down_cnt #(.W(CNT_W)) u_trail (
    .clk(clk),
    .arst_n(arst_n),
    .load(start_line),
    .load_val({trail_reg == RST_COUNT, trail_reg}),
    .dec(in_trail && tick),
    .last(trail_last)
  );

  // binning frozen per line; mid-line writes apply next line
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hbin_line_reg <= 4'h1;
    else if (start_line)
      hbin_line_reg <= hbin_eff;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      LS_IDLE:
        if (line_start)
          state_next = LS_LEAD;
      LS_LEAD:
        if (tick && lead_last)
          state_next = LS_DIGI;
      LS_DIGI:
        if (sample && pix_last)
          state_next = LS_TRAIL;
      LS_TRAIL:
        if (tick && trail_last)
          state_next = LS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= LS_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      col_reg <= 1'b0;
      adc_reg <= 1'b0;
      ldone_reg <= 1'b0;
    end
    else
    begin
      col_reg <= tick && (state_reg != LS_IDLE);
      adc_reg <= sample;
      ldone_reg <= in_trail && tick && trail_last;
    end
  end

  // --------------------------------------------------------------
  // row flush and frame complete
  // --------------------------------------------------------------
  // a new flush request cancels a finish in the same cycle
  assign row_fin = row_active_reg && tick && row_last && !flush_start;

  ccdgr_down_cnt #(.W(CNT_W)) u_row (
    .clk(clk),
    .arst_n(arst_n),
    .load(flush_start),
    .load_val({rows_reg == RST_COUNT, rows_reg}),
    .dec(row_active_reg && tick),
    .last(row_last)
  );

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      row_active_reg <= 1'b0;
      frame_reg <= 1'b0;
      rshift_reg <= 1'b0;
    end
    else
    begin
      rshift_reg <= row_active_reg && tick;
      if (flush_start)
        row_active_reg <= 1'b1;
      else if (row_fin)
        row_active_reg <= 1'b0;
      if (row_fin)
        frame_reg <= 1'b1;
      else if (flush_start)
        frame_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign bus_rdata = rdata_reg;
  assign pixel_pop = pop_reg;
  assign col_shift = col_reg;
  assign adc_sample = adc_reg;
  assign line_done = ldone_reg;
  assign row_shift = rshift_reg;
  assign frame_done = frame_reg;
  assign temp_setpoint = setpoint_reg;
  assign relay_ctrl = relay_reg;
  assign factory_options_a = opt_a_reg;
  assign factory_options_b = opt_b_reg;
  assign factory_options_c = opt_c_reg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  logic [12:0] phase_n_reg, samp_n_reg, row_n_reg;
  logic [12:0] lead_tgt_reg, pix_tgt_reg, trail_tgt_reg, rows_tgt_reg;
  logic [3:0] bin_n_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_n_reg <= 13'h0000;
      samp_n_reg <= 13'h0000;
      bin_n_reg <= 4'h0;
      lead_tgt_reg <= 13'h0000;
      pix_tgt_reg <= 13'h0000;
      trail_tgt_reg <= 13'h0000;
    end
    else
    begin
      if (state_next != state_reg)
        phase_n_reg <= 13'h0000;
      else if (tick)
        phase_n_reg <= phase_n_reg + 13'h0001;
      if (start_line)
        samp_n_reg <= 13'h0000;
      else if (sample)
        samp_n_reg <= samp_n_reg + 13'h0001;
      if (start_line || sample)
        bin_n_reg <= 4'h0;
      else if (in_digi && tick)
        bin_n_reg <= bin_n_reg + 4'h1;
      if (start_line)
      begin
        lead_tgt_reg <= {lead_reg == RST_COUNT, lead_reg};
        pix_tgt_reg <= {pix_reg == RST_COUNT, pix_reg};
        trail_tgt_reg <= {trail_reg == RST_COUNT, trail_reg};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      row_n_reg <= 13'h0000;
      rows_tgt_reg <= 13'h0000;
    end
    else if (flush_start)
    begin
      row_n_reg <= 13'h0000;
      rows_tgt_reg <= {rows_reg == RST_COUNT, rows_reg};
    end
    else if (row_active_reg && tick)
      row_n_reg <= row_n_reg + 13'h0001;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence lead_end_s;
    in_lead && tick && lead_last;
  endsequence
  sequence trail_end_s;
    in_trail && tick && trail_last;
  endsequence
  sequence pix_rd_s;
    bus_rd && (bus_addr == OFS_PIXEL_DATA);
  endsequence

  trail_span_a: assert property (trail_end_s |-> (phase_n_reg + 13'h0001 == trail_tgt_reg) ##1 line_done)
    else $error("trailing skip count wrong");
  lead_span_a: assert property (lead_end_s |-> (phase_n_reg + 13'h0001 == lead_tgt_reg) ##1 in_digi)
    else $error("leading skip count wrong");
  lead_unbinned_a: assert property (in_lead && tick |=> col_shift && !adc_sample)
    else $error("leading shift binned or sampled");
  pixel_span_a: assert property (sample && pix_last |-> (samp_n_reg + 13'h0001 == pix_tgt_reg))
    else $error("pixel count wrong");
  sample_body_a: assert property (adc_sample |-> $past(state_reg) == LS_DIGI)
    else $error("sample outside imaged columns");
  hbin_group_a: assert property (sample |-> (bin_n_reg + 4'h1 == hbin_line_reg))
    else $error("binning group size wrong");
  hbin_zero_a: assert property (start_line && hbin_reg == RST_HBIN |=> hbin_line_reg == 4'h1)
    else $error("zero binning not one");
  frame_rows_a: assert property (row_fin |-> (row_n_reg + 13'h0001 == rows_tgt_reg) ##1 frame_done)
    else $error("frame complete row count wrong");
  frame_rise_a: assert property ($rose(frame_done) |-> $past(row_fin))
    else $error("frame complete without flush end");
  options_write_a: assert property (wr_rows |=> factory_options_c == $past(bus_wdata[OPT_MSB:OPT_LSB]))
    else $error("option nibble not loaded");
  setpoint_write_a: assert property (wr_set |=> temp_setpoint == $past(bus_wdata[TEMP_MSB:0]))
    else $error("set point not loaded");
  relay_write_a: assert property (wr_set |=> relay_ctrl == $past(bus_wdata[RELAY_MSB:RELAY_LSB]))
    else $error("relay byte not loaded");
  pixel_read_a: assert property (pix_rd_s |=> pixel_pop && bus_rdata == $past(pixel_data)
    ##1 (pixel_pop == $past(bus_rd && (bus_addr == OFS_PIXEL_DATA))))
    else $error("pixel read wrong");
  temp_read_a: assert property (bus_rd && bus_addr == OFS_MEAS_TEMP |=> bus_rdata == {8'h00, $past(temp_raw)})
    else $error("temperature read wrong");
  wo_read_a: assert property (bus_rd && bus_addr != OFS_PIXEL_DATA && bus_addr != OFS_MEAS_TEMP
    |=> bus_rdata == 16'h0000 && !pixel_pop)
    else $error("write-only read not zero");

endmodule : ccdgr_regs

/* File: bench/ccdgr_host_model.sv */
// ccdgr_host_model: host side of the register port, one 16-bit word per access.
// assumes the bank takes strobes at rising edges and answers reads one cycle later.
module ccdgr_host_model
  import ccdgr_pkg::*;
(
  // clock
  input wire logic clk,
  // host register port
  output logic [3:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    bus_addr = 4'h1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 16'h0000;
  end

  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
    // one more edge so the written value has settled when the caller looks
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    @(posedge clk);
    d = bus_rdata;
  endtask : rd

  // ----------------------------------------
  // temperature conversions, scale in tenths
  // ----------------------------------------
  // set point code from Celsius
  function automatic logic [7:0] setpoint_code(input int zp, input int t, input int sf10);
    return 8'((zp * 10 + t * sf10) / 10);
  endfunction : setpoint_code

  function automatic int celsius(input logic [7:0] v, input int zp, input int sf10);
    return ((int'(v) - zp) * 10) / sf10;
  endfunction : celsius
endmodule : ccdgr_host_model

/* File: bench/tb_ccd_readout_geometry_regs.sv */
// tb_ccd_readout_geometry_regs: random and corner tests of the register bank.
// assumes the host model drives the bus; bench drives pixel, temperature and starts.
module tb_ccd_readout_geometry_regs
  import ccdgr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] bus_addr;
  logic bus_wr, bus_rd, pixel_pop, col_shift, adc_sample, line_done, row_shift, frame_done;
  logic [15:0] bus_wdata, bus_rdata, rv;
  logic [15:0] pixel_data = 16'h0000;
  logic [7:0] temp_raw = 8'h00;
  logic line_start = 1'b0;
  logic flush_start = 1'b0;
  logic [7:0] temp_setpoint, relay_ctrl, sp;
  logic [3:0] opt_a, opt_b, opt_c;
  int bad_count = 0;
  int cmp_count = 0;
  int pops = 0;
  int p0 = 0;

  initial
  begin
    forever #5 clk = ~clk;
  end

  // counted mid-cycle so a pop is seen before the reading task returns
  always @(negedge clk)
  begin
    if (pixel_pop === 1'b1)
      pops++;
  end

  ccdgr_host_model u_host (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  ccdgr_regs u_dut (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pixel_data(pixel_data),
    .temp_raw(temp_raw), .pixel_pop(pixel_pop), .line_start(line_start),
    .flush_start(flush_start), .col_shift(col_shift), .adc_sample(adc_sample),
    .line_done(line_done), .row_shift(row_shift), .frame_done(frame_done),
    .temp_setpoint(temp_setpoint), .relay_ctrl(relay_ctrl), .factory_options_a(opt_a),
    .factory_options_b(opt_b), .factory_options_c(opt_c));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic int eff(input logic [11:0] v);
    return (v == 12'h000) ? 4096 : int'(v);
  endfunction : eff

  function automatic int hb(input logic [2:0] h);
    return (h == 3'h0) ? 1 : int'(h);
  endfunction : hb

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // one line: counts shifts and samples
  // ----------------------------------------
  task automatic run_line(input logic [11:0] l, input logic [11:0] p, input logic [2:0] h,
    input logic [11:0] t);
    int cols, adcs, pre, post, lim;
    logic [3:0] oa, ob;
    logic done_cs;
    oa = 4'($urandom);
    ob = 4'($urandom);
    cols = 0;
    adcs = 0;
    pre = 0;
    post = 0;
    done_cs = 1'b0;
    lim = (eff(l) + eff(p) * hb(h) + eff(t)) * SHIFT_CYCLES + 40;
    u_host.wr(OFS_LEAD_SKIP, {oa, l});
    u_host.wr(OFS_TRAIL_SKIP, {ob, t});
    u_host.wr(OFS_LINE_PIX, {1'($urandom), h, p});
    chk("options a", 16'(oa), 16'(opt_a));
    chk("options b", 16'(ob), 16'(opt_b));
    @(posedge clk);
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
    repeat (lim)
    begin
      @(posedge clk);
      #1;
      if (col_shift === 1'b1)
        cols++;
      if (col_shift === 1'b1 && adcs == 0 && adc_sample !== 1'b1)
        pre++;
      if (col_shift === 1'b1 && adc_sample !== 1'b1)
        post++;
      if (adc_sample === 1'b1)
      begin
        adcs++;
        post = 0;
      end
      if (line_done === 1'b1)
      begin
        done_cs = col_shift;
        break;
      end
    end
    chk("total shifts", 16'(eff(l) + eff(p) * hb(h) + eff(t)), 16'(cols));
    chk("samples", 16'(eff(p)), 16'(adcs));
    chk("shifts before sample", 16'(eff(l) + hb(h) - 1), 16'(pre));
    chk("trailing shifts", 16'(eff(t)), 16'(post));
    chk("done with shift", 16'h0001, 16'(done_cs));
  endtask : run_line

  // ----------------------------------------
  // one flush: counts rows up to frame done
  // ----------------------------------------
  task automatic run_flush(input logic [11:0] r);
    int rows;
    logic [3:0] oc;
    logic last_rs;
    oc = 4'($urandom);
    rows = 0;
    last_rs = 1'b0;
    u_host.wr(OFS_ROW_COUNT, {oc, r});
    chk("options c", 16'(oc), 16'(opt_c));
    @(posedge clk);
    flush_start <= 1'b1;
    @(posedge clk);
    flush_start <= 1'b0;
    #1;
    chk("frame done cleared", 16'h0000, 16'(frame_done));
    repeat (eff(r) * SHIFT_CYCLES + 30)
    begin
      @(posedge clk);
      #1;
      if (row_shift === 1'b1)
        rows++;
      if (frame_done === 1'b1)
      begin
        last_rs = row_shift;
        break;
      end
    end
    chk("rows flushed", 16'(eff(r)), 16'(rows));
    chk("frame done with row", 16'h0001, 16'(last_rs));
  endtask : run_flush

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(98276));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("frame done at reset", 16'h0000, 16'(frame_done));
    chk("relays at reset", 16'h0000, 16'(relay_ctrl));
    sp = u_host.setpoint_code(200, -10, 25);
    u_host.wr(OFS_SETPOINT, {8'h3C, sp});
    chk("set point code", 16'(sp), 16'(temp_setpoint));
    repeat (6)
    begin
      rv = 16'($urandom);
      u_host.wr(OFS_SETPOINT, rv);
      chk("set point", 16'(rv[7:0]), 16'(temp_setpoint));
      chk("relays", 16'(rv[15:8]), 16'(relay_ctrl));
      u_host.wr(OFS_PIXEL_DATA, ~rv);
      chk("relays after ro write", 16'(rv[15:8]), 16'(relay_ctrl));
      u_host.rd(OFS_SETPOINT, rv);
      chk("write-only read", 16'h0000, rv);
      @(posedge clk);
      pixel_data <= 16'($urandom);
      temp_raw <= 8'($urandom);
      p0 = pops;
      u_host.rd(OFS_PIXEL_DATA, rv);
      chk("pixel word", pixel_data, rv);
      chk("pixel pops", 16'(p0 + 1), 16'(pops));
      u_host.rd(OFS_MEAS_TEMP, rv);
      chk("temperature word", {8'h00, temp_raw}, rv);
    end
    pops = 0;
    u_host.rd(OFS_PIXEL_DATA, rv);
    u_host.rd(OFS_MEAS_TEMP, rv);
    chk("one pop per pixel read", 16'h0001, 16'(pops));
    temp_raw <= sp;
    u_host.rd(OFS_MEAS_TEMP, rv);
    chk("celsius back", 16'hFFF6, 16'(u_host.celsius(rv[7:0], 200, 25)));
    run_line(12'h001, 12'h001, 3'h0, 12'h001);
    run_line(12'h002, 12'h003, 3'h7, 12'h001);
    run_line(12'h003, 12'h002, 3'h3, 12'h004);
    repeat (4)
      run_line(12'($urandom_range(1, 4)), 12'($urandom_range(1, 4)), 3'($urandom), 12'($urandom_range(1, 4)));
    run_line(12'h000, 12'h001, 3'h1, 12'h001);
    run_flush(12'h001);
    run_flush(12'($urandom_range(2, 6)));
    run_flush(12'($urandom_range(2, 6)));
    conclude();
  end

  initial
  begin
    #1_000_000;
    bad_count++;
    conclude();
  end
endmodule : tb_ccd_readout_geometry_regs
